/* rtl/cgc_objen.sv */
// per-object enable bits with abort clear
`timescale 1ns/100ps
`default_nettype none
module cgc_objen (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // software access
  input  wire logic                           wr,
  input  wire logic [cgc_pkg::CGC_NUM_OBJ-1:0] wdata,
  input  wire logic                           abort,
  // state
  output logic      [cgc_pkg::CGC_NUM_OBJ-1:0] object_enable
);
  import cgc_pkg::*;
  genvar g;
  generate
    for (g = 0; g < CGC_NUM_OBJ; g++) begin : gen_obj
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          object_enable[g] <= CGC_OBJEN_RST[g];
        end else if (abort) begin
          object_enable[g] <= 1'b0;
        end else if (wr) begin
          object_enable[g] <= wdata[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/cgc_pkg.sv */
// package for the can general control block
`default_nettype none
package cgc_pkg;
  // register byte addresses (index times four; printed offset not aligned)
  localparam logic [7:0]  CGC_IDX_GCON   = 8'hAB;
  localparam logic [11:0] CGC_ADDR_GCON  = {2'h0, CGC_IDX_GCON, 2'h0};
  localparam logic [11:0] CGC_ADDR_STAT  = 12'h400;
  localparam logic [11:0] CGC_ADDR_OBJEN = 12'h404;
  // control field positions
  localparam int CGC_BIT_ABORT   = 7;
  localparam int CGC_BIT_OVLD    = 6;
  localparam int CGC_BIT_TTC     = 5;
  localparam int CGC_BIT_SYNC    = 4;
  localparam int CGC_BIT_LISTEN  = 3;
  localparam int CGC_BIT_TEST    = 2;
  localparam int CGC_BIT_ENABLE  = 1;
  localparam int CGC_BIT_SRESET  = 0;
  // status field positions
  localparam int CGC_STAT_ENFLAG = 2;
  localparam int CGC_STAT_OVLD   = 6;
  // reset values; the listen bit has no defined reset value, taken as zero
  localparam logic [7:0]  CGC_GCON_RST  = 8'h00;
  localparam logic [14:0] CGC_OBJEN_RST = 15'h0000;
  // clock periods spent in the start state after enable is seen
  localparam int CGC_START_CYCLES = 2;
  localparam int CGC_NUM_OBJ      = 15;
  typedef enum logic [1:0] {
    CGC_IDLE,
    CGC_START,
    CGC_RUN,
    CGC_DRAIN
  } cgc_state_type;
endpackage
`default_nettype wire

/* rtl/cgc_top.sv */
// general control logic of the can controller, apb slave
// Summary of operation
// - abort bit clears every object enable; software clears the abort bit.
// - abort drops pending transmits; frame in progress completes with its flag.
// - overload bit requests an overload frame after next received message.
// - hardware clears overload bit when overload frame transmission starts.
// - bit 5 selects time-triggered mode; clear disables its features.
// - bit 4 picks capture at end of frame, else start of frame.
// - bit 3 enters listening mode; clearing returns to normal.
// - listening: no acknowledge, no transmit, error flags live, counters frozen.
// - bit 1 enables the controller and ungates its clock.
// - clearing bit 1 finishes current frame, then freezes protocol engine.
// - standby keeps tx recessive, receiver off, internal clock stopped.
// - registers and object enables stay accessible while disabled.
// - protocol engine starts two clock periods after enable is set; engine_run rises three periods after the bit is stored.
// - read-only flag shows the real enabled state.
// - bit 0 software reset is ORed with hardware reset, self-clears.
// - after any reset the controller is disabled.
// - control register resets to zero; listen bit value undefined.
// - time-triggered mode sends each frame once, no retransmit.
`timescale 1ns/100ps
`default_nettype none
module cgc_top (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // protocol engine status
  input  wire logic                            frame_active,
  input  wire logic                            frame_received,
  input  wire logic                            ovld_tx_start,
  input  wire logic                            tx_pending,
  input  wire logic                            sof_event,
  input  wire logic                            eof_last_bit,
  input  wire logic                            tx_error,
  // protocol engine control
  output logic                                 engine_run,
  output logic                                 can_clk_en,
  output logic                                 rx_enable,
  output logic                                 tx_force_recessive,
  output logic                                 ack_enable,
  output logic                                 error_count_freeze,
  output logic                                 drop_pending_tx,
  output logic                                 overload_frame_request,
  output logic                                 time_triggered_select,
  output logic                                 timer_capture,
  output logic                                 retransmit_enable,
  output logic                                 controller_reset_n,
  output logic                                 test_mode,
  output logic      [cgc_pkg::CGC_NUM_OBJ-1:0] object_enable
);
  import cgc_pkg::*;

  logic [7:0]    gcon;
  logic [7:0]    next_gcon;
  logic          sreset;
  cgc_state_type state;
  cgc_state_type next_state;
  logic [1:0]    start_cnt;
  logic          enabled_state_flag;

  // apb decode; zero wait states
  wire acc       = psel && penable;
  wire wr_acc    = acc && pwrite;
  wire hit_gcon  = (paddr == CGC_ADDR_GCON);
  wire hit_stat  = (paddr == CGC_ADDR_STAT);
  wire hit_objen = (paddr == CGC_ADDR_OBJEN);
  wire hit_any   = hit_gcon || hit_stat || hit_objen;
  wire wr_gcon   = wr_acc && hit_gcon;
  wire wr_objen  = wr_acc && hit_objen;

  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;

  // field views
  wire abort_all_request     = gcon[CGC_BIT_ABORT];
  wire capture_at_frame_end  = gcon[CGC_BIT_SYNC];
  wire listen_mode           = gcon[CGC_BIT_LISTEN];
  wire controller_enable     = gcon[CGC_BIT_ENABLE];
  wire general_soft_reset    = gcon[CGC_BIT_SRESET];

  // next register value; overload clear by hardware loses to a fresh write
  always_comb begin
    next_gcon = gcon;
    if (ovld_tx_start) begin
      next_gcon[CGC_BIT_OVLD] = 1'b0;
    end
    if (general_soft_reset) begin
      next_gcon[CGC_BIT_SRESET] = 1'b0;
    end
    if (wr_gcon) begin
      next_gcon = pwdata[7:0];
    end
    if (sreset) begin
      next_gcon = CGC_GCON_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcon <= CGC_GCON_RST;
    end else begin
      gcon <= next_gcon;
    end
  end

  // soft reset pulse, one cycle after the bit is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sreset <= 1'b0;
    end else begin
      sreset <= general_soft_reset && !sreset;
    end
  end

  // reset to the protocol engine: hardware or software
  assign controller_reset_n = presetn && !sreset;

  // enable sequencing
  always_comb begin
    next_state = state;
    case (state)
      CGC_IDLE: begin
        if (controller_enable) begin
          next_state = CGC_START;
        end
      end
      CGC_START: begin
        if (!controller_enable) begin
          next_state = CGC_IDLE;
        end else if (start_cnt == 2'(CGC_START_CYCLES - 1)) begin
          next_state = CGC_RUN;
        end
      end
      CGC_RUN: begin
        if (!controller_enable) begin
          next_state = frame_active ? CGC_DRAIN : CGC_IDLE;
        end
      end
      CGC_DRAIN: begin
        if (controller_enable) begin
          next_state = CGC_RUN;
        end else if (!frame_active) begin
          next_state = CGC_IDLE;
        end
      end
      default: begin
        next_state = CGC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= CGC_IDLE;
      start_cnt <= 2'h0;
    end else if (sreset) begin
      state     <= CGC_IDLE;
      start_cnt <= 2'h0;
    end else begin
      state     <= next_state;
      start_cnt <= (state == CGC_START) ? start_cnt + 2'h1 : 2'h0;
    end
  end

  wire running = (state == CGC_RUN) || (state == CGC_DRAIN);
  assign enabled_state_flag = running;

  // engine gating
  assign engine_run         = running;
  assign can_clk_en         = controller_enable || running;
  assign rx_enable          = running;
  // drain counts as running, so tx is not forced recessive until idle
  assign tx_force_recessive = !running || listen_mode;
  assign ack_enable         = running && !listen_mode;
  assign error_count_freeze = listen_mode;
  // frame in progress is untouched; only queued transmits go
  assign drop_pending_tx    = abort_all_request && tx_pending;
  assign overload_frame_request = gcon[CGC_BIT_OVLD] && running;
  assign time_triggered_select  = gcon[CGC_BIT_TTC];
  assign timer_capture = gcon[CGC_BIT_TTC] &&
    (capture_at_frame_end ? eof_last_bit : sof_event);
  // single shot in time-triggered mode
  assign retransmit_enable  = !gcon[CGC_BIT_TTC];
  // the bit drives the test_mode output; software must keep it clear
  assign test_mode          = gcon[CGC_BIT_TEST];

  cgc_objen u_objen (
    .clk           (pclk),
    .rst_n         (controller_reset_n),
    .wr            (wr_objen),
    .wdata         (pwdata[CGC_NUM_OBJ-1:0]),
    .abort         (abort_all_request),
    .object_enable (object_enable)
  );

  // read data, registered on the setup phase
  wire [31:0] rd_mux =
    hit_gcon  ? {24'h000000, gcon} :
    hit_stat  ? {25'h0000000, gcon[CGC_BIT_OVLD], 3'h0,
                 enabled_state_flag, 2'h0} :
    hit_objen ? {17'h00000, object_enable} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // checks
  property p_start_delay;
    @(posedge pclk) disable iff (!presetn || sreset)
    (state == CGC_IDLE && controller_enable) |=>
      !enabled_state_flag ##1 (!enabled_state_flag || !controller_enable)
      ##1 (enabled_state_flag || !controller_enable);
  endproperty
  a_start_delay: assert property (p_start_delay)
    else $error("enable start latency wrong");

  property p_abort_clears;
    @(posedge pclk) disable iff (!controller_reset_n)
    abort_all_request |=> (object_enable == '0);
  endproperty
  a_abort_clears: assert property (p_abort_clears)
    else $error("abort left an object enabled");

  property p_abort_sticky;
    @(posedge pclk) disable iff (!presetn)
    (abort_all_request && !wr_gcon && !sreset) |=> abort_all_request;
  endproperty
  a_abort_sticky: assert property (p_abort_sticky)
    else $error("abort bit cleared by hardware");

  property p_ovld_clear;
    @(posedge pclk) disable iff (!presetn)
    (ovld_tx_start && !wr_gcon) |=> !gcon[CGC_BIT_OVLD];
  endproperty
  a_ovld_clear: assert property (p_ovld_clear)
    else $error("overload request not cleared");

  property p_sreset_pulse;
    @(posedge pclk) disable iff (!presetn)
    $rose(sreset) |=> !sreset && !general_soft_reset && !controller_enable;
  endproperty
  a_sreset_pulse: assert property (p_sreset_pulse)
    else $error("soft reset not a single cycle");

  property p_sreset_follows;
    @(posedge pclk) disable iff (!presetn)
    (general_soft_reset && !sreset) |=> sreset;
  endproperty
  a_sreset_follows: assert property (p_sreset_follows)
    else $error("soft reset bit gave no reset");

  property p_drain;
    @(posedge pclk) disable iff (!controller_reset_n)
    (running && frame_active) |=> running;
  endproperty
  a_drain: assert property (p_drain)
    else $error("engine stopped mid frame");

  property p_standby_tx;
    @(posedge pclk) disable iff (!presetn)
    (state == CGC_IDLE) |-> tx_force_recessive && !rx_enable;
  endproperty
  a_standby_tx: assert property (p_standby_tx)
    else $error("standby drove the bus");

  property p_listen;
    @(posedge pclk) disable iff (!presetn)
    listen_mode |-> !ack_enable && tx_force_recessive && error_count_freeze;
  endproperty
  a_listen: assert property (p_listen)
    else $error("listening mode transmitted");

  property p_single_shot;
    @(posedge pclk) disable iff (!presetn)
    (time_triggered_select && tx_error) |-> !retransmit_enable;
  endproperty
  a_single_shot: assert property (p_single_shot)
    else $error("retransmit allowed in time-triggered mode");

  property p_sreset_clean;
    @(posedge pclk) disable iff (!presetn)
    sreset |=> (gcon == CGC_GCON_RST) && !engine_run;
  endproperty
  a_sreset_clean: assert property (p_sreset_clean)
    else $error("soft reset left control state behind");

  property p_abort_drop;
    @(posedge pclk) disable iff (!presetn)
    (abort_all_request && tx_pending) |-> drop_pending_tx;
  endproperty
  a_abort_drop: assert property (p_abort_drop)
    else $error("pending transmit kept during abort");

  property p_capture_sof;
    @(posedge pclk) disable iff (!presetn)
    (time_triggered_select && !capture_at_frame_end && sof_event) |->
      timer_capture;
  endproperty
  a_capture_sof: assert property (p_capture_sof)
    else $error("timer not captured at frame start");

  property p_no_capture;
    @(posedge pclk) disable iff (!presetn)
    !time_triggered_select |-> !timer_capture;
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("timer captured outside time-triggered mode");

  // only a write or an abort may touch the enables while disabled
  property p_objen_hold;
    @(posedge pclk) disable iff (!controller_reset_n)
    (!controller_enable && !abort_all_request && !wr_objen) |=>
      $stable(object_enable);
  endproperty
  a_objen_hold: assert property (p_objen_hold)
    else $error("object enables changed in standby");

  property p_clk_gate;
    @(posedge pclk) disable iff (!presetn)
    (state == CGC_IDLE && !controller_enable) |-> !can_clk_en;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("engine clock running in standby");

  c_enable: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(enabled_state_flag));
  c_drain: cover property (@(posedge pclk) disable iff (!presetn)
    state == CGC_DRAIN ##1 state == CGC_IDLE);
  c_sreset: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(sreset));
  c_abort: cover property (@(posedge pclk) disable iff (!presetn)
    drop_pending_tx);
  c_capture: cover property (@(posedge pclk) disable iff (!presetn)
    timer_capture);
endmodule
`default_nettype wire

/* verification/cgc_engine_model.sv */
// behavioural protocol engine on the far side of the control block
`timescale 1ns/100ps
`default_nettype none
module cgc_engine_model (
  // clock
  input  wire logic pclk,
  // engine status
  output logic      frame_active,
  output logic      frame_received,
  output logic      ovld_tx_start,
  output logic      tx_pending,
  output logic      sof_event,
  output logic      eof_last_bit,
  output logic      tx_error
);
  time sof_t = 0;
  time eof_t = 0;
  initial begin
    {frame_active, frame_received, ovld_tx_start} = 3'h0;
    {tx_pending, sof_event, eof_last_bit, tx_error} = 4'h0;
  end
  // one frame; start and last bit reported as single-cycle pulses
  task automatic frame(input int len);
    @(posedge pclk);
    sof_event <= 1'b1;
    frame_active <= 1'b1;
    @(posedge pclk);
    sof_t = $time;
    sof_event <= 1'b0;
    repeat (len) @(posedge pclk);
    eof_last_bit <= 1'b1;
    // every frame ends flagged so single-shot mode meets an error
    tx_error <= 1'b1;
    @(posedge pclk);
    eof_t = $time;
    {eof_last_bit, frame_active, frame_received} <= 3'h1;
    tx_error <= 1'b0;
    @(posedge pclk);
    frame_received <= 1'b0;
  endtask
  task automatic ovld;
    @(posedge pclk);
    ovld_tx_start <= 1'b1;
    @(posedge pclk);
    ovld_tx_start <= 1'b0;
  endtask
  task automatic pend(input logic v);
    @(posedge pclk);
    tx_pending <= v;
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the can general control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cgc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, frame_active, frame_received;
  logic        ovld_tx_start, tx_pending, sof_event, eof_last_bit;
  logic        tx_error, engine_run, can_clk_en, rx_enable;
  logic        tx_force_recessive, ack_enable, error_count_freeze;
  logic        drop_pending_tx, overload_frame_request;
  logic        time_triggered_select, timer_capture, retransmit_enable;
  logic        controller_reset_n, test_mode;
  logic [14:0] object_enable, v;
  logic [32:0] exp_q[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          cap_n = 0;
  int          n, lows;
  time         cap_t = 0;

  cgc_top i_cgc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .frame_active, .frame_received,
    .ovld_tx_start, .tx_pending, .sof_event, .eof_last_bit, .tx_error,
    .engine_run, .can_clk_en, .rx_enable, .tx_force_recessive,
    .ack_enable, .error_count_freeze, .drop_pending_tx,
    .overload_frame_request, .time_triggered_select, .timer_capture,
    .retransmit_enable, .controller_reset_n, .test_mode, .object_enable);
  cgc_engine_model i_cgc_engine_model (.pclk, .frame_active,
    .frame_received, .ovld_tx_start, .tx_pending, .sof_event,
    .eof_last_bit, .tx_error);

  always #5 pclk = ~pclk;

  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held from setup until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // read results, with the error response, paired oldest first
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
  always @(posedge pclk)
    if (timer_capture === 1'b1) begin
      cap_t <= $time;
      cap_n <= cap_n + 1;
    end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up;
    end
  end

  // test bit stays clear in every write below
  initial begin
    void'($urandom(19590));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CGC_ADDR_GCON, 33'h0);
    rd(CGC_ADDR_STAT, 33'h0);
    rd(12'h7F0, 33'h1_0000_0000);
    @(negedge pclk);
    chk({tx_force_recessive, rx_enable}, 2'h2);
    v = 15'($urandom);
    wr(CGC_ADDR_OBJEN, {17'h0, v});
    rd(CGC_ADDR_OBJEN, {18'h0, v});
    wr(CGC_ADDR_GCON, 32'h02);
    rd(CGC_ADDR_STAT, 33'h0);
    rd(CGC_ADDR_STAT, 33'h4);
    @(negedge pclk);
    chk({engine_run, can_clk_en, rx_enable}, 3'h7);
    wr(CGC_ADDR_GCON, 32'h0A);
    @(negedge pclk);
    chk({ack_enable, error_count_freeze}, 2'h1);
    wr(CGC_ADDR_GCON, 32'h02);
    @(negedge pclk);
    chk({ack_enable, error_count_freeze}, 2'h2);
    wr(CGC_ADDR_GCON, 32'h22);
    @(negedge pclk);
    chk({time_triggered_select, retransmit_enable}, 2'h2);
    i_cgc_engine_model.frame(4);
    chk(cap_t, i_cgc_engine_model.sof_t);
    wr(CGC_ADDR_GCON, 32'h32);
    i_cgc_engine_model.frame(4);
    chk(cap_t, i_cgc_engine_model.eof_t);
    wr(CGC_ADDR_GCON, 32'h12);
    n = cap_n;
    i_cgc_engine_model.frame(4);
    chk(cap_n, n);
    chk({time_triggered_select, retransmit_enable}, 2'h1);
    wr(CGC_ADDR_GCON, 32'h42);
    @(negedge pclk);
    chk(overload_frame_request, 1'b1);
    i_cgc_engine_model.ovld();
    rd(CGC_ADDR_GCON, 33'h02);
    i_cgc_engine_model.pend(1'b1);
    wr(CGC_ADDR_GCON, 32'h82);
    // enables clear one edge after the abort bit lands
    repeat (2) @(negedge pclk);
    chk({drop_pending_tx, object_enable}, 16'h8000);
    rd(CGC_ADDR_GCON, 33'h82);
    wr(CGC_ADDR_GCON, 32'h02);
    i_cgc_engine_model.pend(1'b0);
    wr(CGC_ADDR_OBJEN, {17'h0, v});
    // disable in mid-frame: engine keeps running until the frame ends
    fork
      i_cgc_engine_model.frame(12);
      begin
        wr(CGC_ADDR_GCON, 32'h0);
        // look once the drain state is in force
        repeat (3) @(negedge pclk);
        chk(engine_run, 1'b1);
      end
    join
    repeat (2) @(negedge pclk);
    chk({engine_run, can_clk_en, tx_force_recessive}, 3'h1);
    rd(CGC_ADDR_OBJEN, {18'h0, v});
    rd(CGC_ADDR_STAT, 33'h0);
    wr(CGC_ADDR_GCON, 32'h03);
    lows = 0;
    repeat (6) @(negedge pclk) if (controller_reset_n === 1'b0) lows++;
    chk(lows, 1);
    rd(CGC_ADDR_GCON, 33'h0);
    rd(CGC_ADDR_STAT, 33'h0);
    rd(CGC_ADDR_OBJEN, 33'h0);
    chk(test_mode, 1'b0);
    wrap_up;
  end
endmodule
`default_nettype wire
